/* testbench.sv */
// self-checking bench for the transmit output and bias configuration register bank
`timescale 1ns/1ps
module testbench;
    // ***************************************************************
    // stimulus, observation and bookkeeping
    // ***************************************************************
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] port;
    } txb_row_t;

    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  bias_monitor_level = 8'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  modulation_amplitude_code;
    logic        output_side_select;
    logic        single_ended_select;
    logic        delayed_deemph_select;
    logic        slow_edge_select;
    logic [3:0]  deemph_strength;
    logic        crossing_shift_direction;
    logic [6:0]  crossing_shift_magnitude;
    logic [9:0]  laser_bias_code;
    logic        digital_pd_monitor_select;
    logic        digital_bias_monitor_select;
    logic [1:0]  photodiode_range;
    logic        auto_power_loop;
    logic [11:0] pd_target_step_na;
    logic        bias_fault;
    int          error_cnt = 0;
    int          checked = 0;
    logic [31:0] rd;
    logic        err;
    txb_row_t    rows [10];

    txb_regs txb_regs_i (
        .mclk                        (mclk),
        .reset                       (reset),
        .psel                        (psel),
        .penable                     (penable),
        .pwrite                      (pwrite),
        .paddr                       (paddr),
        .pwdata                      (pwdata),
        .pstrb                       (pstrb),
        .prdata                      (prdata),
        .pready                      (pready),
        .pslverr                     (pslverr),
        .bias_monitor_level          (bias_monitor_level),
        .modulation_amplitude_code   (modulation_amplitude_code),
        .output_side_select          (output_side_select),
        .single_ended_select         (single_ended_select),
        .delayed_deemph_select       (delayed_deemph_select),
        .slow_edge_select            (slow_edge_select),
        .deemph_strength             (deemph_strength),
        .crossing_shift_direction    (crossing_shift_direction),
        .crossing_shift_magnitude    (crossing_shift_magnitude),
        .laser_bias_code             (laser_bias_code),
        .digital_pd_monitor_select   (digital_pd_monitor_select),
        .digital_bias_monitor_select (digital_bias_monitor_select),
        .photodiode_range            (photodiode_range),
        .auto_power_loop             (auto_power_loop),
        .pd_target_step_na           (pd_target_step_na),
        .bias_fault                  (bias_fault)
    );

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // ***************************************************************
    // helper tasks
    // ***************************************************************
    // one comparison; unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // let a few edges pass, then look between edges
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // register byte as it appears on the configuration ports
    function automatic logic [7:0] port_val(input logic [7:0] a);
        case (a)
            8'h00:   port_val = modulation_amplitude_code;
            8'h04:   port_val = {output_side_select, single_ended_select,
                                 delayed_deemph_select, slow_edge_select, deemph_strength};
            8'h08:   port_val = {crossing_shift_direction, crossing_shift_magnitude};
            8'h10:   port_val = {1'b0, digital_pd_monitor_select,
                                 digital_bias_monitor_select, 5'b0_0000};
            default: port_val = 8'h00;
        endcase
    endfunction

    // single place where the run ends
    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(40 * 20000);
        error_cnt++;
        end_of_test();
    end

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        rows = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h04, 8'h80, 8'h80}, '{8'h04, 8'h40, 8'h40},
                 '{8'h04, 8'h2F, 8'h2F}, '{8'h04, 8'h10, 8'h10}, '{8'h08, 8'hFF, 8'hFF},
                 '{8'h08, 8'h01, 8'h01}, '{8'h10, 8'h40, 8'h40}, '{8'h10, 8'h20, 8'h20},
                 '{8'h10, 8'h9C, 8'h00}};
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        idle(1);
        // reset values, ports and registers
        chk({22'h0, laser_bias_code}, 32'h0000_0000);
        chk({20'h0, pd_target_step_na}, 32'h0000_02EE);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 8'h00, 4'hF, rd, err);
            chk(rd, 32'h0000_0000);
            chk({24'h0, port_val(8'(i * 4))}, 32'h0000_0000);
        end
        // ordinary field rows: write, read back, look at the ports
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, 4'hF, rd, err);
            apb(1'b0, rows[i].addr, 8'h00, 4'hF, rd, err);
            chk(rd, {24'h0, rows[i].wdata});
            chk({24'h0, port_val(rows[i].addr)}, {24'h0, rows[i].port});
        end
        // write with low strobe off is ignored
        apb(1'b1, 8'h00, 8'h3C, 4'hE, rd, err);
        idle(1);
        chk({24'h0, modulation_amplitude_code}, 32'h0000_00A5);
        // unmapped address is refused
        apb(1'b1, 8'h20, 8'h55, 4'hF, rd, err);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 8'h20, 8'h00, 4'hF, rd, err);
        chk(rd, 32'h0000_0000);
        // bias high stages only; low part applies the pair
        apb(1'b1, 8'h0C, 8'h12, 4'hF, rd, err);
        idle(2);
        chk({22'h0, laser_bias_code}, 32'h0000_0000);
        apb(1'b0, 8'h0C, 8'h00, 4'hF, rd, err);
        chk(rd, 32'h0000_0012);
        apb(1'b0, 8'h1C, 8'h00, 4'hF, rd, err);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        apb(1'b1, 8'h10, 8'h03, 4'hF, rd, err);
        idle(1);
        chk({22'h0, laser_bias_code}, 32'h0000_004B);
        // full-scale code in open loop is held under the current limit
        apb(1'b1, 8'h0C, 8'hFF, 4'hF, rd, err);
        apb(1'b1, 8'h10, 8'h03, 4'hF, rd, err);
        idle(1);
        chk({22'h0, laser_bias_code}, 32'h0000_03FC);
        // photodiode range steps, every code
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, 8'h18, 8'(r), 4'hF, rd, err);
            idle(2);
            chk({30'h0, photodiode_range}, 32'(r));
            chk({20'h0, pd_target_step_na}, (r == 0) ? 32'h0000_02EE :
                (r == 1) ? 32'h0000_05DC : 32'h0000_0BB8);
        end
        // closed loop: the full code passes unclamped
        apb(1'b1, 8'h18, 8'h04, 4'hF, rd, err);
        apb(1'b1, 8'h10, 8'h03, 4'hF, rd, err);
        idle(1);
        chk({31'h0, auto_power_loop}, 32'h0000_0001);
        chk({22'h0, laser_bias_code}, 32'h0000_03FF);
        // back to open loop: the held full code drops to the ceiling by itself
        apb(1'b1, 8'h18, 8'h00, 4'hF, rd, err);
        idle(2);
        chk({22'h0, laser_bias_code}, 32'h0000_03FC);
        apb(1'b0, 8'h1C, 8'h00, 4'hF, rd, err);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        // zero level met zero threshold in the rows, so the flag is already set
        chk({31'h0, bias_fault}, 32'h0000_0001);
        apb(1'b1, 8'h14, 8'h40, 4'hF, rd, err);
        apb(1'b1, 8'h1C, 8'h01, 4'hF, rd, err);
        // bias monitor fault above threshold, then cleared
        apb(1'b1, 8'h10, 8'h20, 4'hF, rd, err);
        idle(4);
        chk({31'h0, bias_fault}, 32'h0000_0000);
        @(posedge mclk);
        bias_monitor_level <= 8'h50;
        idle(6);
        chk({31'h0, bias_fault}, 32'h0000_0001);
        @(posedge mclk);
        bias_monitor_level <= 8'h10;
        idle(4);
        apb(1'b1, 8'h1C, 8'h01, 4'hF, rd, err);
        idle(2);
        chk({31'h0, bias_fault}, 32'h0000_0000);
        // second reset in mid-run clears the modulation and bias codes
        @(posedge mclk);
        reset <= 1'b1;
        idle(2);
        @(posedge mclk);
        reset <= 1'b0;
        idle(1);
        chk({24'h0, modulation_amplitude_code}, 32'h0000_0000);
        chk({22'h0, laser_bias_code}, 32'h0000_0000);
        end_of_test();
    end
endmodule

/* txb_bias_if.sv */
// carrier between the register bank and the bias code stage
`timescale 1ns/1ps
interface txb_bias_if;
    logic [7:0]                   high;
    logic [txb_pkg::BIAS_LO_W-1:0] low;
    logic                         commit;
    logic                         open_loop;
    logic [txb_pkg::BIAS_W-1:0]   applied;
    logic                         clamped;

    modport regs (output high, output low, output commit, output open_loop,
                  input applied, input clamped);
    modport stage (input high, input low, input commit, input open_loop,
                   output applied, output clamped);
endinterface

/* txb_bias_stage.sv */
// stage that applies the 10-bit laser bias code as one word
`timescale 1ns/1ps
module txb_bias_stage (
    input  wire logic mclk,
    input  wire logic reset,
    txb_bias_if.stage bias
);
    logic [txb_pkg::BIAS_W-1:0] code_d;

    // ***************************************************************
    // code assembly and open loop limit
    // ***************************************************************
    // open loop: 1023 steps would pass the 150 mA ceiling, so the top codes are held
    always_comb begin
        code_d = {bias.high, bias.low};
        if (bias.open_loop && code_d > txb_pkg::BIAS_CODE_LIMIT) begin
            code_d = txb_pkg::BIAS_CODE_LIMIT;
        end
    end

    // whole word moves in one edge, so the bias never sees a half update
    always_ff @(posedge mclk) begin
        if (reset) begin
            bias.applied <= '0;
            bias.clamped <= 1'b0;
        end else if (bias.commit) begin
            bias.applied <= code_d;
            bias.clamped <= bias.open_loop && ({bias.high, bias.low} > code_d);
        end else if (bias.open_loop && bias.applied > txb_pkg::BIAS_CODE_LIMIT) begin
            // a high code kept from closed loop drops to the ceiling on the mode change
            bias.applied <= txb_pkg::BIAS_CODE_LIMIT;
            bias.clamped <= 1'b1;
        end
    end
endmodule

/* txb_pkg.sv */
// constants and field layout of the transmit output and bias configuration bank
package txb_pkg;
    // ***************************************************************
    // register map (byte addresses, one aligned word each)
    // ***************************************************************
    localparam logic [7:0] OFS_MOD_AMP   = 8'h00;
    localparam logic [7:0] OFS_SHAPE     = 8'h04;
    localparam logic [7:0] OFS_CROSS     = 8'h08;
    localparam logic [7:0] OFS_BIAS_HI   = 8'h0C;
    localparam logic [7:0] OFS_BIAS_LO   = 8'h10;
    localparam logic [7:0] OFS_THRESH    = 8'h14;
    localparam logic [7:0] OFS_LOOP      = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1C;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int OUTSEL_BIT    = 7;
    localparam int MODE_BIT      = 6;
    localparam int STEP_BIT      = 5;
    localparam int SLOW_BIT      = 4;
    localparam int DEEMPH_W      = 4;
    localparam int CP_SIGN_BIT   = 7;
    localparam int CP_MAG_W      = 7;
    localparam int BIAS_W        = 10;
    localparam int BIAS_LO_W     = 2;
    localparam int DMONP_BIT     = 6;
    localparam int DMONB_BIT     = 5;
    localparam int PDRNG_W       = 2;
    localparam int APC_BIT       = 2;
    localparam int ST_FAULT_BIT  = 0;
    localparam int ST_PEND_BIT   = 1;
    localparam int ST_CLAMP_BIT  = 2;

    // ***************************************************************
    // analog scale figures
    // ***************************************************************
    localparam int MOD_STEP_UVPP    = 9500;
    localparam int MOD_FULL_UVPP    = 2400000;
    localparam int BIAS_STEP_UA     = 147;
    localparam int BIAS_MAX_UA      = 150000;
    localparam logic [BIAS_W-1:0] BIAS_CODE_LIMIT = BIAS_W'(BIAS_MAX_UA / BIAS_STEP_UA);
    localparam logic [11:0] PD_STEP_R0_NA = 12'd750;
    localparam logic [11:0] PD_STEP_R1_NA = 12'd1500;
    localparam logic [11:0] PD_STEP_R2_NA = 12'd3000;
    localparam logic [21:0] MOD_FULL_CODE = 22'(MOD_FULL_UVPP / 1000);
endpackage

/* txb_regs.sv */
// apb register bank for transmit output shaping and laser bias configuration
`timescale 1ns/1ps
module txb_regs (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  bias_monitor_level,
    output logic      [7:0]  modulation_amplitude_code,
    output logic             output_side_select,
    output logic             single_ended_select,
    output logic             delayed_deemph_select,
    output logic             slow_edge_select,
    output logic      [3:0]  deemph_strength,
    output logic             crossing_shift_direction,
    output logic      [6:0]  crossing_shift_magnitude,
    output logic      [9:0]  laser_bias_code,
    output logic             digital_pd_monitor_select,
    output logic             digital_bias_monitor_select,
    output logic      [1:0]  photodiode_range,
    output logic             auto_power_loop,
    output logic      [11:0] pd_target_step_na,
    output logic             bias_fault
);
    // ***************************************************************
    // storage
    // ***************************************************************
    logic [7:0]  mod_amp_q;
    logic [7:0]  shape_q;
    logic [7:0]  cross_q;
    logic [7:0]  bias_hi_q;
    logic [7:0]  bias_lo_q;
    logic [7:0]  thresh_q;
    logic [7:0]  loop_q;
    logic        fault_q;
    logic        pend_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0]  mon_meta_q;
    logic [7:0]  mon_sync_q;
    logic [11:0] pd_step_q;
    logic [7:0]  rd_d;
    logic        hit_d;
    logic        wr_en;
    logic        fault_set;
    logic        fault_clr;

    txb_bias_if bias_c ();

    // ***************************************************************
    // decode helpers
    // ***************************************************************
    // address decode is used by both read and write paths
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            txb_pkg::OFS_MOD_AMP, txb_pkg::OFS_SHAPE, txb_pkg::OFS_CROSS,
            txb_pkg::OFS_BIAS_HI, txb_pkg::OFS_BIAS_LO, txb_pkg::OFS_THRESH,
            txb_pkg::OFS_LOOP, txb_pkg::OFS_STATUS: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // range code to target step per bias code, in nA (times coupling ratio)
    function automatic logic [11:0] pd_step(input logic [1:0] rng);
        case (rng)
            2'b00:   pd_step = txb_pkg::PD_STEP_R0_NA;
            2'b01:   pd_step = txb_pkg::PD_STEP_R1_NA;
            default: pd_step = txb_pkg::PD_STEP_R2_NA;
        endcase
    endfunction

    // ***************************************************************
    // apb handshake
    // ***************************************************************
    // one wait state: pready rises in the second access cycle
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];
    assign hit_d = addr_mapped(paddr);

    // read mux; narrow registers sit in the low byte
    always_comb begin
        rd_d = 8'h00;
        case (paddr)
            txb_pkg::OFS_MOD_AMP: rd_d = mod_amp_q;
            txb_pkg::OFS_SHAPE:   rd_d = shape_q;
            txb_pkg::OFS_CROSS:   rd_d = cross_q;
            txb_pkg::OFS_BIAS_HI: rd_d = bias_hi_q;
            txb_pkg::OFS_BIAS_LO: rd_d = bias_lo_q;
            txb_pkg::OFS_THRESH:  rd_d = thresh_q;
            txb_pkg::OFS_LOOP:    rd_d = loop_q;
            txb_pkg::OFS_STATUS: begin
                rd_d[txb_pkg::ST_FAULT_BIT] = fault_q;
                rd_d[txb_pkg::ST_PEND_BIT]  = pend_q;
                rd_d[txb_pkg::ST_CLAMP_BIT] = bias_c.clamped;
            end
            default: rd_d = 8'h00;
        endcase
    end

    // answer stage; unmapped addresses answer with pslverr
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !hit_d;
            if (psel && penable && !pready_q && !pwrite) begin
                prdata_q <= {24'h00_0000, rd_d};
            end
        end
    end

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    // every bit is plain read/write, reserved bits too
    always_ff @(posedge mclk) begin
        if (reset) begin
            mod_amp_q <= txb_pkg::REG_RESET;
            shape_q   <= txb_pkg::REG_RESET;
            cross_q   <= txb_pkg::REG_RESET;
            bias_hi_q <= txb_pkg::REG_RESET;
            bias_lo_q <= txb_pkg::REG_RESET;
            thresh_q  <= txb_pkg::REG_RESET;
            loop_q    <= txb_pkg::REG_RESET;
        end else if (wr_en) begin
            case (paddr)
                txb_pkg::OFS_MOD_AMP: mod_amp_q <= pwdata[7:0];
                txb_pkg::OFS_SHAPE:   shape_q   <= pwdata[7:0];
                txb_pkg::OFS_CROSS:   cross_q   <= pwdata[7:0];
                txb_pkg::OFS_BIAS_HI: bias_hi_q <= pwdata[7:0];
                txb_pkg::OFS_BIAS_LO: bias_lo_q <= pwdata[7:0];
                txb_pkg::OFS_THRESH:  thresh_q  <= pwdata[7:0];
                txb_pkg::OFS_LOOP:    loop_q    <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // bias code commit
    // ***************************************************************
    // high part alone only stages; the low write applies both parts together
    always_ff @(posedge mclk) begin
        if (reset) begin
            pend_q <= 1'b0;
        end else if (wr_en && paddr == txb_pkg::OFS_BIAS_LO) begin
            pend_q <= 1'b0;
        end else if (wr_en && paddr == txb_pkg::OFS_BIAS_HI) begin
            pend_q <= 1'b1;
        end
    end

    assign bias_c.high      = bias_hi_q;
    assign bias_c.low       = pwdata[txb_pkg::BIAS_LO_W-1:0];
    assign bias_c.commit    = wr_en && paddr == txb_pkg::OFS_BIAS_LO;
    assign bias_c.open_loop = !loop_q[txb_pkg::APC_BIT];

    txb_bias_stage u_stage (
        .mclk  (mclk),
        .reset (reset),
        .bias  (bias_c)
    );

    // ***************************************************************
    // bias monitor fault
    // ***************************************************************
    // monitor level arrives from the converter domain; two flops first
    always_ff @(posedge mclk) begin
        if (reset) begin
            mon_meta_q <= 8'h00;
            mon_sync_q <= 8'h00;
        end else begin
            mon_meta_q <= bias_monitor_level;
            mon_sync_q <= mon_meta_q;
        end
    end

    // compare only when the digital monitor owns the level
    assign fault_set = bias_lo_q[txb_pkg::DMONB_BIT] && mon_sync_q >= thresh_q;
    assign fault_clr = wr_en && paddr == txb_pkg::OFS_STATUS && pwdata[txb_pkg::ST_FAULT_BIT];

    // sticky flag; a fresh event beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_q <= 1'b0;
        end else if (fault_set) begin
            fault_q <= 1'b1;
        end else if (fault_clr) begin
            fault_q <= 1'b0;
        end
    end

    // closed loop step scale follows the range code
    always_ff @(posedge mclk) begin
        if (reset) begin
            pd_step_q <= txb_pkg::PD_STEP_R0_NA;
        end else begin
            pd_step_q <= pd_step(loop_q[txb_pkg::PDRNG_W-1:0]);
        end
    end

    // ***************************************************************
    // outputs, each straight from a flip-flop
    // ***************************************************************
    assign prdata                      = prdata_q;
    assign pready                      = pready_q;
    assign pslverr                     = pslverr_q;
    assign modulation_amplitude_code   = mod_amp_q;
    assign output_side_select          = shape_q[txb_pkg::OUTSEL_BIT];
    assign single_ended_select         = shape_q[txb_pkg::MODE_BIT];
    assign delayed_deemph_select       = shape_q[txb_pkg::STEP_BIT];
    assign slow_edge_select            = shape_q[txb_pkg::SLOW_BIT];
    assign deemph_strength             = shape_q[txb_pkg::DEEMPH_W-1:0];
    assign crossing_shift_direction    = cross_q[txb_pkg::CP_SIGN_BIT];
    assign crossing_shift_magnitude    = cross_q[txb_pkg::CP_MAG_W-1:0];
    assign laser_bias_code             = bias_c.applied;
    assign digital_pd_monitor_select   = bias_lo_q[txb_pkg::DMONP_BIT];
    assign digital_bias_monitor_select = bias_lo_q[txb_pkg::DMONB_BIT];
    assign photodiode_range            = loop_q[txb_pkg::PDRNG_W-1:0];
    assign auto_power_loop             = loop_q[txb_pkg::APC_BIT];
    assign pd_target_step_na           = pd_step_q;
    assign bias_fault                  = fault_q;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // swing in mV worked out from the code, for the full scale check
    localparam int MOD_STEP_MV_X10 = txb_pkg::MOD_STEP_UVPP / 100;
    logic [21:0] swing_mvpp;
    assign swing_mvpp = 22'(mod_amp_q) * 22'(MOD_STEP_MV_X10) / 22'd10;

    // shaping and crossing fields follow the written byte one edge later
    mod_code_a: assert property (wr_en && paddr == txb_pkg::OFS_MOD_AMP
        |=> modulation_amplitude_code == $past(pwdata[7:0]))
        else $error("modulation code not taken");
    // top code lands 22 mV past nominal full scale, so allow 23 mV over it
    mod_range_a: assert property (swing_mvpp <= txb_pkg::MOD_FULL_CODE + 22'd23)
        else $error("swing past full scale step");
    out_side_a: assert property (wr_en && paddr == txb_pkg::OFS_SHAPE
        |=> output_side_select == $past(pwdata[7]) && single_ended_select == $past(pwdata[6]))
        else $error("output side or mode wrong");
    mode_hold_a: assert property (!(wr_en && paddr == txb_pkg::OFS_SHAPE)
        |=> $stable(single_ended_select) && $stable(slow_edge_select))
        else $error("output mode changed without write");
    deemph_a: assert property (wr_en && paddr == txb_pkg::OFS_SHAPE
        |=> deemph_strength == $past(pwdata[3:0]) && delayed_deemph_select == $past(pwdata[5]))
        else $error("de-emphasis field wrong");
    edge_a: assert property (wr_en && paddr == txb_pkg::OFS_SHAPE
        |=> slow_edge_select == $past(pwdata[4]))
        else $error("edge speed wrong");
    cross_a: assert property (wr_en && paddr == txb_pkg::OFS_CROSS
        |=> {crossing_shift_direction, crossing_shift_magnitude} == $past(pwdata[7:0]))
        else $error("crossing fields wrong");

    // bias word: whole pair in closed loop, step scale from the range code
    bias_word_a: assert property (bias_c.commit && auto_power_loop
        |=> laser_bias_code == {bias_hi_q, bias_lo_q[1:0]})
        else $error("bias word not assembled");
    pd_step_a: assert property (##1 photodiode_range == 2'b01
        |=> pd_target_step_na == txb_pkg::PD_STEP_R1_NA)
        else $error("range step wrong");
    // ceiling holds from the second open loop edge on, after a mode change too
    bias_limit_a: assert property (!auto_power_loop && !$past(auto_power_loop)
        |-> laser_bias_code <= txb_pkg::BIAS_CODE_LIMIT)
        else $error("open loop bias past ceiling");

    // monitor selects, plain readback and the sticky fault flag
    mon_sel_a: assert property (wr_en && paddr == txb_pkg::OFS_BIAS_LO
        |=> digital_pd_monitor_select == $past(pwdata[6])
            && digital_bias_monitor_select == $past(pwdata[5]))
        else $error("monitor selects wrong");
    reserved_rw_a: assert property (psel && penable && pready && !pwrite
        && paddr == txb_pkg::OFS_BIAS_LO |-> prdata[7:0] == bias_lo_q)
        else $error("bias low readback wrong");
    fault_a: assert property (fault_set |=> bias_fault)
        else $error("fault not flagged");
    fault_clear_a: assert property (fault_clr && !fault_set |=> !bias_fault)
        else $error("fault not cleared");

    // bias moves only on a low write or when the loop mode has just changed
    no_glitch_a: assert property (!bias_c.commit && $stable(auto_power_loop)
        |=> $stable(laser_bias_code))
        else $error("bias moved without low write");
    // bus answer: one wait state, and refusal of unmapped addresses
    answer_a: assert property (psel && !penable ##1 psel && penable |-> ##1 pready)
        else $error("no answer after one wait state");
    refuse_a: assert property (psel && penable && pready && !hit_d |-> pslverr)
        else $error("unmapped address not refused");

    // main scenarios worth seeing at least once
    commit_c: cover property (wr_en && paddr == txb_pkg::OFS_BIAS_HI ##[1:20] bias_c.commit);
    fault_c: cover property (fault_set ##[1:20] fault_clr);
    err_c: cover property (pready && pslverr);
    clamp_c: cover property (bias_c.clamped && !auto_power_loop);
endmodule
